//--- shared/led_fault_consts.vh
`ifndef LED_FAULT_CONSTS_VH
`define LED_FAULT_CONSTS_VH

// register offsets (register index on the internal register port)
`define REG_GEN_MASK_ADDR     8'h0c
`define REG_LED_MASK_ADDR     8'h0d
`define REG_DECODE_STAT_ADDR  8'h0e
`define REG_GEN_STAT_ADDR     8'h10

// widths
`define REG_WIDTH             13
`define LED_COUNT             12

// reset values
`define LED_MASK_RESET        12'h000
`define GEN_MASK_RESET        1'h0

// field positions
`define THERMAL_MASK_BIT      0
`define DECODE_DONE_BIT       4
`define ADDR_HIGH_BIT         3
`define GRADE_HIGH_BIT        2
`define ADDR_LOW_BIT          1
`define GRADE_LOW_BIT         0
`define STAT_THERMAL_BIT      0
`define STAT_SHORT_BIT        3
`define STAT_OPEN_BIT         4

`endif

//--- design/led_mask_gate.v
`timescale 1ns/1ps
`include "led_fault_consts.vh"

// gates per-led open and short faults with the per-led mask
module led_mask_gate (
   // fault inputs
   input  wire [`LED_COUNT-1:0] led_open_fault,
   input  wire [`LED_COUNT-1:0] led_shorted_fault,
   // mask
   input  wire [`LED_COUNT-1:0] per_led_fault_mask,
   // result
   output wire                  open_unmasked,
   output wire                  short_unmasked
);

   // a set mask bit removes that led from both fault sums
   assign open_unmasked  = |(led_open_fault & ~per_led_fault_mask);
   assign short_unmasked = |(led_shorted_fault & ~per_led_fault_mask);

endmodule

//--- design/led_fault_mask_status.v
// Operation
// - thermal warning drives fault pin unless the thermal mask bit is set.
// - twelve per-led mask bits block that led's open and short faults.
// - decode-done flag at bit 4 reads 1 once the measurement completes.
// - grade resistor high flag at bit 2 set on over range or open.
// - address resistor low flag at bit 1 set on under range or short.
// - grade resistor low flag at bit 0 set on under range or short.
// - fault pin asserted while the unmasked thermal warning or any unmasked led's open or short fault is high.
`timescale 1ns/1ps
`include "led_fault_consts.vh"

module led_fault_mask_status (
   // clock and reset
   input  wire                   core_clk,
   input  wire                   arst_n,
   // register port from the serial interface
   input  wire [7:0]             reg_addr,
   input  wire                   reg_wr,
   input  wire [`REG_WIDTH-1:0]  reg_wdata,
   output reg  [`REG_WIDTH-1:0]  reg_rdata,
   // fault sources
   input  wire                   thermal_warning_flag,
   input  wire [`LED_COUNT-1:0]  led_open_fault,
   input  wire [`LED_COUNT-1:0]  led_shorted_fault,
   // resistor measurement results
   input  wire                   resistor_decode_done,
   input  wire                   address_resistor_high,
   input  wire                   grade_resistor_high,
   input  wire                   address_resistor_low,
   input  wire                   grade_resistor_low,
   // pin and mask visibility
   output reg                    fault_pin_n,
   output wire                   thermal_warning_pin_mask,
   output wire [`LED_COUNT-1:0]  per_led_fault_mask
);

   reg                  th_mask_q;
   reg [`LED_COUNT-1:0] led_mask_q;
   reg [4:0]            decode_stat_q;
   reg                  th_q;
   reg [`LED_COUNT-1:0] open_q;
   reg [`LED_COUNT-1:0] short_q;
   wire                 open_unmasked;
   wire                 short_unmasked;
   wire                 fault_d;

   assign thermal_warning_pin_mask = th_mask_q;
   assign per_led_fault_mask       = led_mask_q;

   // mask registers written over the register port
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         th_mask_q  <= `GEN_MASK_RESET;
         led_mask_q <= `LED_MASK_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `REG_GEN_MASK_ADDR)
            th_mask_q <= reg_wdata[`THERMAL_MASK_BIT];
         if (reg_addr == `REG_LED_MASK_ADDR)
            led_mask_q <= reg_wdata[`LED_COUNT-1:0];
      end
   end

   // status capture is independent of the masks so software sees raw faults
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         decode_stat_q <= 5'h00;
         th_q          <= 1'b0;
         open_q        <= {`LED_COUNT{1'b0}};
         short_q       <= {`LED_COUNT{1'b0}};
      end else begin
         decode_stat_q[`DECODE_DONE_BIT] <= resistor_decode_done;
         decode_stat_q[`ADDR_HIGH_BIT]   <= address_resistor_high;
         decode_stat_q[`GRADE_HIGH_BIT]  <= grade_resistor_high;
         decode_stat_q[`ADDR_LOW_BIT]    <= address_resistor_low;
         decode_stat_q[`GRADE_LOW_BIT]   <= grade_resistor_low;
         th_q    <= thermal_warning_flag;
         open_q  <= led_open_fault;
         short_q <= led_shorted_fault;
      end
   end

   // per-led gating kept apart so the mask width tracks the led count
   led_mask_gate u_gate (
      .led_open_fault     (open_q),
      .led_shorted_fault  (short_q),
      .per_led_fault_mask (led_mask_q),
      .open_unmasked      (open_unmasked),
      .short_unmasked     (short_unmasked)
   );

   // any unmasked source pulls the pin low
   assign fault_d = (th_q & ~th_mask_q)
                  | open_unmasked | short_unmasked;

   // registered pin avoids glitches from combinational mask changes
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         fault_pin_n <= 1'b1;
      else
         fault_pin_n <= ~fault_d;
   end

   // read mux; unmapped offsets read as zero
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= {`REG_WIDTH{1'b0}};
      end else begin
         case (reg_addr)
            `REG_GEN_MASK_ADDR:
               reg_rdata <= {12'h000, th_mask_q};
            `REG_LED_MASK_ADDR:
               reg_rdata <= {1'b0, led_mask_q};
            `REG_DECODE_STAT_ADDR:
               reg_rdata <= {8'h00, decode_stat_q};
            `REG_GEN_STAT_ADDR:
               reg_rdata <= {8'h00, |open_q, |short_q, 2'b00, th_q};
            default:
               reg_rdata <= {`REG_WIDTH{1'b0}};
         endcase
      end
   end

endmodule

//--- sim/led_fault_checker_properties.sv
`timescale 1ns/1ps
module led_fault_checker (
   input wire        core_clk, arst_n, thermal_warning_flag, fault_pin_n,
   input wire        thermal_warning_pin_mask, resistor_decode_done,
   input wire        address_resistor_high, grade_resistor_high,
   input wire        address_resistor_low, grade_resistor_low,
   input wire [7:0]  reg_addr,
   input wire [12:0] reg_rdata,
   input wire [11:0] led_open_fault, led_shorted_fault, per_led_fault_mask
);
   wire [4:0]  rs = {resistor_decode_done, address_resistor_high,
      grade_resistor_high, address_resistor_low, grade_resistor_low};
   wire [11:0] lf = led_open_fault | led_shorted_fault;
   wire [11:0] lm = per_led_fault_mask;
   wire        th = thermal_warning_flag;
   wire        tm = thermal_warning_pin_mask;
   reg  [1:0]  up_q;
   reg  [4:0]  rs1_q, rs2_q;
   reg         ra_q;
   wire [4:0]  hold = ~(rs1_q ^ rs2_q);
   // wait two edges after reset so history never reaches into reset
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) up_q <= 2'h0;
      else up_q <= {up_q[0], 1'b1};
   end
   // reads are judged only on steady flags, either latency then agrees
   always @(posedge core_clk) begin
      rs1_q <= rs;
      rs2_q <= rs1_q;
      ra_q  <= reg_addr == 8'h0e;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!up_q[1]);
   pin_from_flags_a: assert property (
      fault_pin_n == !($past(th, 2) && !$past(tm) ||
      |($past(lf, 2) & ~$past(lm)))) else $error("pin mismatch");
   thermal_drive_a: assert property (
      $past(th, 2) && !$past(tm) |-> !fault_pin_n) else $error("thermal pin");
   led_mask_a: assert property (
      !$past(th, 2) && ($past(lf, 2) & ~$past(lm)) == 12'h000 |-> fault_pin_n)
      else $error("masked led on pin");
   decode_done_a: assert property (
      ra_q && hold[4] |-> reg_rdata[4] == rs1_q[4]) else $error("done flag");
   addr_high_a: assert property (
      ra_q && hold[3] |-> reg_rdata[3] == rs1_q[3]) else $error("addr high");
   grade_high_a: assert property (
      ra_q && hold[2] |-> reg_rdata[2] == rs1_q[2]) else $error("grade high");
   addr_low_a: assert property (
      ra_q && hold[1] |-> reg_rdata[1] == rs1_q[1]) else $error("addr low");
   grade_low_a: assert property (
      ra_q && hold[0] |-> reg_rdata[0] == rs1_q[0]) else $error("grade low");
endmodule
bind led_fault_mask_status led_fault_checker led_fault_checker_inst (
   .core_clk, .arst_n, .thermal_warning_flag, .fault_pin_n,
   .thermal_warning_pin_mask, .resistor_decode_done, .address_resistor_high,
   .grade_resistor_high, .address_resistor_low, .grade_resistor_low,
   .reg_addr, .reg_rdata, .led_open_fault, .led_shorted_fault,
   .per_led_fault_mask);

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb;
   reg         core_clk = 0, arst_n = 0, reg_wr = 0, th = 0;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [12:0] reg_wdata = 13'h0000;
   reg  [11:0] op = 12'h000, sh = 12'h000;
   reg  [4:0]  rs = 5'h00;
   wire [12:0] reg_rdata;
   wire        fault_pin_n, th_mask;
   wire [11:0] led_mask;
   int         fails = 0, n_tests = 0;
   always #20 core_clk = ~core_clk;
   led_fault_mask_status led_fault_mask_status_inst (.core_clk, .arst_n,
      .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .thermal_warning_flag(th),
      .led_open_fault(op), .led_shorted_fault(sh),
      .resistor_decode_done(rs[4]), .address_resistor_high(rs[3]),
      .grade_resistor_high(rs[2]), .address_resistor_low(rs[1]),
      .grade_resistor_low(rs[0]), .fault_pin_n,
      .thermal_warning_pin_mask(th_mask), .per_led_fault_mask(led_mask));
   // inputs always move 1 ns after the edge so sampling is never a race
   task step(input int n); repeat (n) @(posedge core_clk); #1; endtask
   task wr(input [7:0] a, input [12:0] d);
      reg_addr = a; reg_wdata = d; reg_wr = 1; step(1); reg_wr = 0;
   endtask
   // status takes one edge, read data one more
   task rd(input [7:0] a, input [12:0] e); reg_addr = a; step(2);
      `CHK(reg_rdata, e) endtask
   task pin(input e); step(2); `CHK(fault_pin_n, e) endtask
   task conclude;
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      step(10); arst_n = 1;
      rd(8'h0d, 13'h0000); `CHK(fault_pin_n, 1'b1)
      $display("reset test done");
      th = 1; pin(0);
      wr(8'h0c, 13'h0001); pin(1);
      `CHK(th_mask, 1'b1)
      rd(8'h0c, 13'h0001);
      rd(8'h10, 13'h0001);
      $display("thermal test done");
      th = 0; op = 12'h020; pin(0);
      wr(8'h0d, 13'h0020); pin(1);
      sh = 12'h800; pin(0);
      wr(8'h0d, 13'h0fff); pin(1);
      `CHK(led_mask, 12'hfff)
      rd(8'h0d, 13'h0fff);
      rd(8'h10, 13'h0018);
      $display("led mask test done");
      for (int i = 0; i < 5; i++) begin
         rs = 5'h01 << i;
         rd(8'h0e, 13'h0001 << i);
      end
      $display("decode test done");
      conclude;
   end
   // whole run is under 100 cycles, so 50 us means a hang
   initial begin #50000; fails++; conclude; end
endmodule
